// *** shared/bars_pkg.sv ***
// Offsets, field layouts and reset values of the bridge auxiliary register set
package bars_pkg;
   // Register byte offsets
   localparam logic [11:0] OFS_SYS_ERR_RESP = 12'h040;
   localparam logic [11:0] OFS_ERR_INFO = 12'h044;
   localparam logic [11:0] OFS_PCI_ERR_RESP = 12'h048;
   localparam logic [11:0] OFS_FBB_EN = 12'h05C;
   localparam logic [11:0] OFS_WIN_EN = 12'h060;
   localparam logic [11:0] OFS_CFG_ADDR = 12'h064;
   localparam logic [11:0] OFS_CFG_DATA = 12'h068;
   localparam logic [11:0] OFS_IO_DATA = 12'h06C;
   localparam logic [11:0] OFS_MEM_DATA = 12'h070;
   localparam logic [11:0] OFS_FEATURE_ID = 12'h7B4;
   localparam logic [11:0] OFS_SYS_ARB_MASK = 12'h800;
   localparam logic [11:0] OFS_PCI_ARB_MASK = 12'h804;
   localparam logic [11:0] OFS_PCI_ARB_PRIO = 12'h808;
   localparam logic [11:0] OFS_ARB_MODE = 12'h80C;
   localparam logic [11:0] OFS_PCI_CMD = 12'h810;
   localparam logic [11:0] OFS_PCI_STS = 12'h814;
   localparam logic [11:0] OFS_MLAT = 12'h81C;
   localparam logic [11:0] OFS_FEAT_EN = 12'h820;
   localparam logic [11:0] OFS_RD_HINTS = 12'h824;
   localparam logic [11:0] OFS_WR_HINTS = 12'h828;
   localparam logic [11:0] OFS_TLAT = 12'h830;
   // Error information bit positions
   localparam int ERR_SYS_VALID_BIT = 0;
   localparam int ERR_PCI_VALID_BIT = 1;
   localparam int ERR_SYS_NONMST_BIT = 2;
   localparam int ERR_PCI_NONMST_BIT = 3;
   // Fixed values and masks
   localparam logic [31:0] FEATURE_ID_VALUE = 32'h0000_0001;
   localparam logic [31:0] WIN_EN_WR_MASK = 32'h7FFF_FFFE;
   localparam logic [7:0] PCI_CMD_WR_MASK = 8'hEF;
   localparam logic [7:0] PCI_STS_STICKY = 8'h9F;
   localparam logic [7:0] PCI_STS_FIXED = 8'h20;
   localparam logic [8:0] PCI_STS_FBBC = 9'h100;
   localparam logic [7:0] MLAT_WR_MASK = 8'hF8;
   localparam logic [7:0] TLAT_WR_MASK = 8'hFC;
   localparam int TLAT_EN_BIT = 7;
   localparam logic [6:0] TLAT_DEFAULT_COUNT = 7'h08;
   localparam int WIN_LSB = 23;
   // Reset value shared by all writable state
   localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
endpackage

// *** src/bars_regs.sv ***
// Auxiliary and version-dependent register set of the system-bus to PCI bridge
// How it works
// - System-bus error captures the address the bridge drove into system responder register.
// - PCI error captures the address the bridge drove into PCI responder register.
// - System responder address is meaningful only while info bit 0 is one.
// - PCI responder address is meaningful only while info bit 1 is one.
// - System-bus error in a non-bridge-mastered transaction sets info bit 2.
// - PCI error in a non-bridge-mastered transaction sets info bit 3.
// - Bit 0 of fast back-to-back register enables fast writes; others read zero.
// - Fast back-to-back enable comes up cleared.
// - Window enable register holds one bit per 8MB window, 32 windows.
// - System-bus transactions forward to PCI only inside an enabled window.
// - Topmost window enable bit is hardwired to zero.
// - Lowest window enable bit is hardwired to zero.
// - Feature identification register always reads 0x0000_0001.
// - Any write to PCI status clears its recorded status; reads return events.
// - System arbitration mask register masks the bridge's system-bus request line.
// - PCI arbitration mask masks request lines of PCI devices on the arbiter.
// - Seven-bit PCI priority field selects the built-in arbiter scheme.
// - Arbitration mode holds two bits for performance-mode arbitration.
// - Master latency timer value, in PCI clocks, used as PCI master.
// - Target latency register sets subsequent-latency count as PCI target.
// - Config address port holds indirect target address; config data port carries data.
// - Separate data ports carry indirect PCI I/O and memory data.
// - I/O clear command clears every PCI status bit not hardwired.
`timescale 1ns/1ps
module bars_regs
   import bars_pkg::*;
(
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   // Register port
   input wire logic [11:0] reg_addr,
   input wire logic [31:0] reg_wr_data,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   output logic [31:0] reg_rd_data,
   // Error events from the bus engines
   input wire logic sys_err_event,
   input wire logic [31:0] sys_err_addr,
   input wire logic sys_err_non_master,
   input wire logic pci_err_event,
   input wire logic [31:0] pci_err_addr,
   input wire logic pci_err_non_master,
   // PCI status events and the I/O clear command
   input wire logic [7:0] pci_status_set,
   input wire logic io_clear_cmd,
   // System-bus transaction decode
   input wire logic sys_txn_valid,
   input wire logic [31:0] sys_txn_addr,
   output logic fwd_to_pci,
   // Configuration towards the engines
   output logic fbb_enable,
   output logic [31:0] window_enable,
   output logic [31:0] sys_arb_mask,
   output logic [31:0] pci_arb_mask,
   output logic [6:0] pci_arb_priority,
   output logic [1:0] arb_mode,
   output logic [7:0] pci_command,
   output logic [7:0] master_latency,
   output logic [6:0] target_latency_count,
   output logic [31:0] config_address,
   output logic [31:0] config_data,
   output logic [31:0] io_data,
   output logic [31:0] memory_data,
   output logic [31:0] feature_enable,
   output logic [31:0] read_hints,
   output logic [31:0] write_hints
);

   // Window index of a system-bus address
   function automatic logic [4:0] bars_win_idx(input logic [31:0] a);
      bars_win_idx = a[WIN_LSB +: 5];
   endfunction

   logic [31:0] sys_resp_reg;
   logic [31:0] pci_resp_reg;
   logic [3:0] err_info_reg;
   logic [7:0] pci_sts_reg;
   logic [7:0] tlat_reg;
   logic [31:0] rd_data_next;
   logic wr_hit_sts;

   assign wr_hit_sts = reg_wr_en && (reg_addr == OFS_PCI_STS);

   // System-side error capture, first error held until clear
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sys_resp_reg <= RESET_VALUE;
      end else if (clk_en && sys_err_event && !err_info_reg[ERR_SYS_VALID_BIT]) begin
         sys_resp_reg <= sys_err_addr;
      end
   end

   // PCI-side error capture, first error held until clear
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pci_resp_reg <= RESET_VALUE;
      end else if (clk_en && pci_err_event && !err_info_reg[ERR_PCI_VALID_BIT]) begin
         pci_resp_reg <= pci_err_addr;
      end
   end

   // Error information flags; set wins over the clear command, writes ignored
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         err_info_reg <= 4'h0;
      end else if (clk_en) begin
         err_info_reg <= (io_clear_cmd ? 4'h0 : err_info_reg) | {
            pci_err_event && pci_err_non_master,
            sys_err_event && sys_err_non_master,
            pci_err_event,
            sys_err_event};
      end
   end

   // PCI status: write or clear command empties it, events set, set wins
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pci_sts_reg <= 8'h00;
      end else if (clk_en) begin
         pci_sts_reg <= ((wr_hit_sts || io_clear_cmd) ? 8'h00 : pci_sts_reg)
            | (pci_status_set & PCI_STS_STICKY);
      end
   end

   // Software-writable control registers
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fbb_enable <= 1'b0;
         window_enable <= RESET_VALUE;
         sys_arb_mask <= RESET_VALUE;
         pci_arb_mask <= RESET_VALUE;
         pci_arb_priority <= 7'h00;
         arb_mode <= 2'h0;
         pci_command <= 8'h00;
         master_latency <= 8'h00;
         tlat_reg <= 8'h00;
         config_address <= RESET_VALUE;
         config_data <= RESET_VALUE;
         io_data <= RESET_VALUE;
         memory_data <= RESET_VALUE;
         feature_enable <= RESET_VALUE;
         read_hints <= RESET_VALUE;
         write_hints <= RESET_VALUE;
      end else if (clk_en && reg_wr_en) begin
         case (reg_addr)
            OFS_FBB_EN: fbb_enable <= reg_wr_data[0];
            OFS_WIN_EN: window_enable <= reg_wr_data & WIN_EN_WR_MASK;
            OFS_SYS_ARB_MASK: sys_arb_mask <= reg_wr_data;
            OFS_PCI_ARB_MASK: pci_arb_mask <= reg_wr_data;
            OFS_PCI_ARB_PRIO: pci_arb_priority <= reg_wr_data[6:0];
            OFS_ARB_MODE: arb_mode <= reg_wr_data[1:0];
            OFS_PCI_CMD: pci_command <= reg_wr_data[7:0] & PCI_CMD_WR_MASK;
            OFS_MLAT: master_latency <= reg_wr_data[7:0] & MLAT_WR_MASK;
            OFS_TLAT: tlat_reg <= reg_wr_data[7:0] & TLAT_WR_MASK;
            OFS_CFG_ADDR: config_address <= reg_wr_data;
            OFS_CFG_DATA: config_data <= reg_wr_data;
            OFS_IO_DATA: io_data <= reg_wr_data;
            OFS_MEM_DATA: memory_data <= reg_wr_data;
            OFS_FEAT_EN: feature_enable <= reg_wr_data;
            OFS_RD_HINTS: read_hints <= reg_wr_data;
            OFS_WR_HINTS: write_hints <= reg_wr_data;
            default: ;
         endcase
      end
   end

   // Effective target latency count, fixed default when not enabled
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         target_latency_count <= TLAT_DEFAULT_COUNT;
      end else if (clk_en) begin
         target_latency_count <= tlat_reg[TLAT_EN_BIT] ? tlat_reg[6:0] : TLAT_DEFAULT_COUNT;
      end
   end

   // Forwarding decision for a system-bus transaction
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fwd_to_pci <= 1'b0;
      end else if (clk_en) begin
         fwd_to_pci <= sys_txn_valid && window_enable[bars_win_idx(sys_txn_addr)];
      end
   end

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      rd_data_next = 32'h0000_0000;
      case (reg_addr)
         OFS_SYS_ERR_RESP: rd_data_next = sys_resp_reg;
         OFS_ERR_INFO: rd_data_next = {28'h0000000, err_info_reg};
         OFS_PCI_ERR_RESP: rd_data_next = pci_resp_reg;
         OFS_FBB_EN: rd_data_next = {31'h00000000, fbb_enable};
         OFS_WIN_EN: rd_data_next = window_enable;
         OFS_CFG_ADDR: rd_data_next = config_address;
         OFS_CFG_DATA: rd_data_next = config_data;
         OFS_IO_DATA: rd_data_next = io_data;
         OFS_MEM_DATA: rd_data_next = memory_data;
         OFS_FEATURE_ID: rd_data_next = FEATURE_ID_VALUE;
         OFS_SYS_ARB_MASK: rd_data_next = sys_arb_mask;
         OFS_PCI_ARB_MASK: rd_data_next = pci_arb_mask;
         OFS_PCI_ARB_PRIO: rd_data_next = {25'h0000000, pci_arb_priority};
         OFS_ARB_MODE: rd_data_next = {30'h00000000, arb_mode};
         OFS_PCI_CMD: rd_data_next = {24'h000000, pci_command};
         OFS_PCI_STS: rd_data_next = {23'h000000, PCI_STS_FBBC[8], pci_sts_reg | PCI_STS_FIXED};
         OFS_MLAT: rd_data_next = {24'h000000, master_latency};
         OFS_FEAT_EN: rd_data_next = feature_enable;
         OFS_RD_HINTS: rd_data_next = read_hints;
         OFS_WR_HINTS: rd_data_next = write_hints;
         OFS_TLAT: rd_data_next = {24'h000000, tlat_reg};
         default: rd_data_next = 32'h0000_0000;
      endcase
   end

   // Read data stand one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         reg_rd_data <= RESET_VALUE;
      end else if (clk_en) begin
         reg_rd_data <= reg_rd_en ? rd_data_next : 32'h0000_0000;
      end
   end

   // Checks on the register behaviour
   AST_SYS_CAPTURE: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && sys_err_event && !err_info_reg[0] |=> sys_resp_reg == $past(sys_err_addr))
      else $error("system responder address not captured");
   AST_PCI_CAPTURE: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && pci_err_event && !err_info_reg[1] |=> pci_resp_reg == $past(pci_err_addr))
      else $error("PCI responder address not captured");
   AST_SYS_VALID: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && sys_err_event |=> err_info_reg[0])
      else $error("system valid flag not set");
   AST_PCI_VALID: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && pci_err_event |=> err_info_reg[1])
      else $error("PCI valid flag not set");
   AST_SYS_NONMST: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && sys_err_event && sys_err_non_master |=> err_info_reg[2])
      else $error("system non-master flag lost");
   AST_PCI_NONMST: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && pci_err_event && pci_err_non_master |=> err_info_reg[3])
      else $error("PCI non-master flag lost");
   AST_FBB_READ: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_rd_en && reg_addr == OFS_FBB_EN |=> reg_rd_data[31:1] == 31'h0
         && reg_rd_data[0] == $past(fbb_enable))
      else $error("fast back-to-back read wrong");
   AST_WIN_HARD: assert property (@(posedge clk_sys) disable iff (reset)
      !window_enable[31] && !window_enable[0])
      else $error("hardwired window bit set");
   AST_FORWARD: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && sys_txn_valid ##1 clk_en[*1] |-> fwd_to_pci ==
         $past(window_enable[bars_win_idx(sys_txn_addr)]))
      else $error("forward decision wrong");
   AST_FEATURE_ID: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_rd_en && reg_addr == OFS_FEATURE_ID |=> reg_rd_data == 32'h0000_0001)
      else $error("feature id read wrong");
   AST_STS_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && wr_hit_sts && pci_status_set == 8'h00 |=> pci_sts_reg == 8'h00)
      else $error("status write did not clear");
   AST_STS_CMD_CLEAR: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && io_clear_cmd |=> pci_sts_reg == ($past(pci_status_set) & 8'h9F))
      else $error("clear command result wrong");
   AST_INFO_RO: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_ERR_INFO && !sys_err_event && !pci_err_event
         && !io_clear_cmd |=> $stable(err_info_reg))
      else $error("error info changed by write");
   AST_SYS_RESP_RO: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_SYS_ERR_RESP && !sys_err_event |=> $stable(sys_resp_reg))
      else $error("system responder changed by write");
   AST_PCI_RESP_RO: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_PCI_ERR_RESP && !pci_err_event |=> $stable(pci_resp_reg))
      else $error("PCI responder changed by write");
   AST_STS_READ: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_rd_en && reg_addr == OFS_PCI_STS |=> reg_rd_data[31:8] == 24'h000001 && reg_rd_data[6:5] == 2'h1)
      else $error("status fixed bits wrong");

   // Checks on the write paths of the control registers
   AST_FBB_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_FBB_EN |=>
         fbb_enable == $past(reg_wr_data[0]))
      else $error("fast back-to-back enable not written");
   AST_WIN_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_WIN_EN |=>
         window_enable == ($past(reg_wr_data) & 32'h7FFF_FFFE))
      else $error("window enable not written");
   AST_SYS_MASK: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_SYS_ARB_MASK |=>
         sys_arb_mask == $past(reg_wr_data))
      else $error("system arbitration mask not written");
   AST_PCI_MASK: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_PCI_ARB_MASK |=>
         pci_arb_mask == $past(reg_wr_data))
      else $error("PCI arbitration mask not written");
   AST_ARB_PRIO: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_PCI_ARB_PRIO |=>
         pci_arb_priority == $past(reg_wr_data[6:0]))
      else $error("arbitration priority not written");
   AST_ARB_MODE: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_ARB_MODE |=>
         arb_mode == $past(reg_wr_data[1:0]))
      else $error("arbitration mode not written");
   AST_MLAT_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_MLAT |=>
         master_latency == ($past(reg_wr_data[7:0]) & 8'hF8))
      else $error("master latency not written");
   AST_CFG_ADDR: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_CFG_ADDR |=>
         config_address == $past(reg_wr_data))
      else $error("config address not written");
   AST_CFG_DATA: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_CFG_DATA |=>
         config_data == $past(reg_wr_data))
      else $error("config data not written");
   AST_IO_DATA: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_IO_DATA |=>
         io_data == $past(reg_wr_data))
      else $error("I/O data not written");
   AST_MEM_DATA: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr_en && reg_addr == OFS_MEM_DATA |=>
         memory_data == $past(reg_wr_data))
      else $error("memory data not written");

   // Checks on derived values, hardwired bits and the read port
   AST_TLAT_COUNT: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en |=> target_latency_count == ($past(tlat_reg[7]) ? $past(tlat_reg[6:0]) : 7'h08))
      else $error("target latency count wrong");
   AST_MLAT_LOW: assert property (@(posedge clk_sys) disable iff (reset)
      master_latency[2:0] == 3'h0)
      else $error("master latency low bits set");
   AST_CMD_BIT4: assert property (@(posedge clk_sys) disable iff (reset)
      !pci_command[4])
      else $error("command bit 4 set");
   AST_RD_IDLE: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && !reg_rd_en |=> reg_rd_data == 32'h0000_0000)
      else $error("read data not zero outside a read");
   AST_UNMAPPED_READ: assert property (@(posedge clk_sys) disable iff (reset)
      clk_en && reg_rd_en && reg_addr == 12'h818 |=> reg_rd_data == 32'h0000_0000)
      else $error("unmapped offset read non-zero");
   AST_FREEZE: assert property (@(posedge clk_sys) disable iff (reset)
      !clk_en |=> $stable(reg_rd_data) && $stable(sys_arb_mask) && $stable(err_info_reg))
      else $error("state moved while enable low");

   // Scenario covers
   COV_SYS_ERR: cover property (@(posedge clk_sys) disable iff (reset)
      clk_en && sys_err_event ##1 clk_en && reg_rd_en && reg_addr == OFS_SYS_ERR_RESP);
   COV_STS_WRITE: cover property (@(posedge clk_sys) disable iff (reset)
      pci_sts_reg != 8'h00 ##1 clk_en && wr_hit_sts);
   COV_FORWARD: cover property (@(posedge clk_sys) disable iff (reset) fwd_to_pci);
   COV_SET_AND_CLEAR: cover property (@(posedge clk_sys) disable iff (reset)
      clk_en && io_clear_cmd && pci_err_event);

endmodule // bars_regs

// *** bench/bars_engine_model.sv ***
// Behavioural model of the bus engines that report errors to the register set
`timescale 1ns/1ps
module bars_engine_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Requests from the bench
   input wire logic sys_req,
   input wire logic pci_req,
   input wire logic nm_req,
   input wire logic [31:0] addr_req,
   // Error reports towards the register set
   output logic sys_err_event,
   output logic [31:0] sys_err_addr,
   output logic sys_err_non_master,
   output logic pci_err_event,
   output logic [31:0] pci_err_addr,
   output logic pci_err_non_master
);
   // One-cycle reports; qualifiers scramble outside a report
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         {sys_err_event, sys_err_addr, sys_err_non_master} <= '0;
         {pci_err_event, pci_err_addr, pci_err_non_master} <= '0;
      end else begin
         sys_err_event <= sys_req;
         sys_err_addr <= sys_req ? addr_req : ~sys_err_addr;
         sys_err_non_master <= sys_req ? nm_req : ~sys_err_non_master;
         pci_err_event <= pci_req;
         pci_err_addr <= pci_req ? addr_req : ~pci_err_addr;
         pci_err_non_master <= pci_req ? nm_req : ~pci_err_non_master;
      end
   end
endmodule // bars_engine_model

// *** bench/test_bars_regs.sv ***
// Self-checking bench for the bridge auxiliary register set
`timescale 1ns/1ps
module test_bars_regs;
   import bars_pkg::*;
   logic clk_sys, reset, clk_en, reg_wr_en, reg_rd_en, sys_err_event, sys_err_non_master;
   logic pci_err_event, pci_err_non_master, sys_req, pci_req, nm_req, io_clear_cmd;
   logic sys_txn_valid, fwd_to_pci, fbb_enable;
   logic [11:0] reg_addr;
   logic [31:0] reg_wr_data, reg_rd_data, sys_err_addr, pci_err_addr, addr_req, a1, a2;
   logic [31:0] sys_txn_addr, window_enable, sys_arb_mask, pci_arb_mask, config_address;
   logic [31:0] config_data, io_data, memory_data, feature_enable, read_hints, write_hints;
   logic [7:0] pci_status_set, pci_command, master_latency;
   logic [6:0] pci_arb_priority, target_latency_count;
   logic [1:0] arb_mode;
   logic rd_seen = 1'b0;
   logic [31:0] exp_q[$];
   logic [31:0] wdat [16];
   int failures = 0;
   int n_tests = 0;
   logic [11:0] ofs [16] = '{OFS_FBB_EN, OFS_WIN_EN, OFS_CFG_ADDR, OFS_CFG_DATA, OFS_IO_DATA,
      OFS_MEM_DATA, OFS_SYS_ARB_MASK, OFS_PCI_ARB_MASK, OFS_PCI_ARB_PRIO, OFS_ARB_MODE,
      OFS_PCI_CMD, OFS_MLAT, OFS_FEAT_EN, OFS_RD_HINTS, OFS_WR_HINTS, OFS_TLAT};
   logic [31:0] msk [16] = '{32'h0000_0001, 32'h7FFF_FFFE, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
      32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_007F,
      32'h0000_0003, 32'h0000_00EF, 32'h0000_00F8, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
      32'hFFFF_FFFF, 32'h0000_00FC};

   bars_regs u_bars_regs (.clk_sys, .reset, .clk_en, .reg_addr, .reg_wr_data, .reg_wr_en,
      .reg_rd_en, .reg_rd_data, .sys_err_event, .sys_err_addr, .sys_err_non_master,
      .pci_err_event, .pci_err_addr, .pci_err_non_master, .pci_status_set, .io_clear_cmd,
      .sys_txn_valid, .sys_txn_addr, .fwd_to_pci, .fbb_enable, .window_enable, .sys_arb_mask,
      .pci_arb_mask, .pci_arb_priority, .arb_mode, .pci_command, .master_latency,
      .target_latency_count, .config_address, .config_data, .io_data, .memory_data,
      .feature_enable, .read_hints, .write_hints);
   bars_engine_model u_bars_engine_model (.clk_sys, .reset, .sys_req, .pci_req, .nm_req,
      .addr_req, .sys_err_event, .sys_err_addr, .sys_err_non_master, .pci_err_event,
      .pci_err_addr, .pci_err_non_master);

   // Clock generation
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Verdict and end of run
   task end_sim();
      $display("Comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Value comparison
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One-cycle register write
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wr_data <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk_sys);
      reg_wr_en <= 1'b0;
   endtask
   // One-cycle register read; expectation queued for the monitor
   task rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_rd_en <= 1'b0;
   endtask
   // Error report through the engine model
   task eng(input logic s, input logic p, input logic nm, input logic [31:0] a);
      @(posedge clk_sys);
      {sys_req, pci_req, nm_req, addr_req} <= {s, p, nm, a};
      @(posedge clk_sys);
      {sys_req, pci_req} <= 2'b00;
      repeat (2) @(posedge clk_sys);
   endtask
   // Status event or clear command pulse
   task pulse(input logic [7:0] s, input logic clr);
      @(posedge clk_sys);
      {pci_status_set, io_clear_cmd} <= {s, clr};
      @(posedge clk_sys);
      {pci_status_set, io_clear_cmd} <= 9'h000;
   endtask
   // Read monitor: read data stand in the cycle after the strobe
   always @(posedge clk_sys) rd_seen <= reg_rd_en;
   always @(negedge clk_sys) begin
      if (rd_seen === 1'b1) chk(reg_rd_data, exp_q.pop_front());
   end
   // Watchdog
   initial begin
      #100000;
      failures++;
      end_sim();
   end
   // Main sequence
   initial begin
      {reset, clk_en} = 2'b11;
      {reg_wr_en, reg_rd_en, sys_req, pci_req, nm_req, io_clear_cmd, sys_txn_valid} = 7'h00;
      {reg_addr, reg_wr_data, addr_req, sys_txn_addr, pci_status_set} = '0;
      a1 = $urandom(34);
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      for (int i = 0; i < 16; i++) rd(ofs[i], RESET_VALUE);
      rd(OFS_FEATURE_ID, FEATURE_ID_VALUE);
      rd(OFS_PCI_STS, 32'h0000_0120);
      @(negedge clk_sys);
      chk({25'h0, target_latency_count}, 32'h0000_0008);
      for (int i = 0; i < 16; i++) begin
         wdat[i] = $urandom();
         wr(ofs[i], wdat[i]);
         rd(ofs[i], wdat[i] & msk[i]);
      end
      @(negedge clk_sys);
      chk({31'h0, fbb_enable}, wdat[0] & 32'h0000_0001);
      chk(window_enable, wdat[1] & WIN_EN_WR_MASK);
      chk(memory_data, wdat[5]);
      chk(config_address, wdat[2]);
      chk(config_data, wdat[3]);
      chk(io_data, wdat[4]);
      chk(sys_arb_mask, wdat[6]);
      chk(pci_arb_mask, wdat[7]);
      chk({25'h0, pci_arb_priority}, wdat[8] & 32'h0000_007F);
      chk({30'h0, arb_mode}, wdat[9] & 32'h0000_0003);
      chk({24'h0, pci_command}, wdat[10] & 32'h0000_00EF);
      chk({24'h0, master_latency}, wdat[11] & 32'h0000_00F8);
      chk(feature_enable, wdat[12]);
      chk(read_hints, wdat[13]);
      chk(write_hints, wdat[14]);
      // Frozen write while the enable is low
      @(posedge clk_sys);
      clk_en <= 1'b0;
      wr(OFS_SYS_ARB_MASK, ~wdat[6]);
      clk_en <= 1'b1;
      rd(OFS_SYS_ARB_MASK, wdat[6]);
      wr(OFS_FEATURE_ID, 32'hFFFF_FFFF);
      wr(12'h818, 32'hFFFF_FFFF);
      rd(OFS_FEATURE_ID, FEATURE_ID_VALUE);
      rd(12'h818, 32'h0000_0000);
      wr(OFS_TLAT, 32'h0000_0097);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys) chk({25'h0, target_latency_count}, 32'h0000_0014);
      wr(OFS_TLAT, 32'h0000_0014);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys) chk({25'h0, target_latency_count}, 32'h0000_0008);
      // Window decode, single window then all writable windows
      for (int p = 0; p < 2; p++) begin
         wr(OFS_WIN_EN, p ? 32'hFFFF_FFFF : 32'h8000_0021);
         for (int w = 0; w < 32; w++) begin
            @(posedge clk_sys);
            sys_txn_valid <= 1'b1;
            sys_txn_addr <= (32'(w) << 23) | ($urandom() & 32'h007F_FFFF);
            @(posedge clk_sys);
            sys_txn_valid <= 1'b0;
            @(negedge clk_sys);
            chk({31'h0, fwd_to_pci}, 32'((p ? (w != 0 && w != 31) : (w == 5))));
         end
      end
      // Error capture and read-only logging
      a2 = $urandom();
      eng(1'b1, 1'b0, 1'b1, a1);
      rd(OFS_SYS_ERR_RESP, a1);
      rd(OFS_ERR_INFO, 32'h0000_0005);
      eng(1'b0, 1'b1, 1'b0, a2);
      rd(OFS_PCI_ERR_RESP, a2);
      rd(OFS_ERR_INFO, 32'h0000_0007);
      eng(1'b0, 1'b1, 1'b1, ~a2);
      wr(OFS_SYS_ERR_RESP, ~a1);
      wr(OFS_PCI_ERR_RESP, ~a1);
      wr(OFS_ERR_INFO, 32'h0000_0000);
      rd(OFS_SYS_ERR_RESP, a1);
      rd(OFS_PCI_ERR_RESP, a2);
      rd(OFS_ERR_INFO, 32'h0000_000F);
      // Status events, write clear and clear command
      pulse(8'h9F, 1'b0);
      rd(OFS_PCI_STS, 32'h0000_01BF);
      wr(OFS_PCI_STS, $urandom());
      rd(OFS_PCI_STS, 32'h0000_0120);
      pulse(PCI_STS_STICKY, 1'b0);
      pulse(8'h00, 1'b1);
      rd(OFS_PCI_STS, 32'h0000_0120);
      rd(OFS_ERR_INFO, 32'h0000_0000);
      eng(1'b1, 1'b0, 1'b0, a2);
      rd(OFS_SYS_ERR_RESP, a2);
      rd(OFS_ERR_INFO, 32'h0000_0001);
      repeat (3) @(posedge clk_sys);
      end_sim();
   end
endmodule // test_bars_regs
